/* interval_host_model.sv */
// host side model: mode and count writes, latched reads
module interval_host_model (
	// clock
	input wire logic clk_i,
	// host access
	output logic mode_wr_o,
	output logic [2:0] mode_o,
	output logic two_byte_o,
	output logic count_wr_o,
	output logic [7:0] wr_data_o,
	output logic latch_cmd_o,
	output logic rd_o,
	input wire logic [7:0] rd_data_i
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [3:0] MODE_STB = 4'h8;
	localparam logic [3:0] COUNT_STB = 4'h4;
	localparam logic [3:0] LATCH_STB = 4'h2;
	localparam logic [3:0] READ_STB = 4'h1;
	initial begin
		{mode_wr_o, count_wr_o, latch_cmd_o, rd_o, two_byte_o} = 5'h00;
		mode_o = 3'h2;
		wr_data_o = 8'h00;
	end
	// strobes selected by a code, so no port is passed by reference
	task automatic pulse(input logic [3:0] sel);
		@(negedge clk_i);
		{mode_wr_o, count_wr_o, latch_cmd_o, rd_o} = sel;
		@(negedge clk_i);
		{mode_wr_o, count_wr_o, latch_cmd_o, rd_o} = 4'h0;
	endtask
	task automatic set_mode(input logic [2:0] m, input logic two);
		mode_o = m;
		two_byte_o = two;
		pulse(MODE_STB);
	endtask
	task automatic write_count(input logic [15:0] v, input logic two);
		wr_data_o = v[7:0];
		pulse(COUNT_STB);
		wr_data_o = two ? v[15:8] : 8'h00;
		if (two) pulse(COUNT_STB);
	endtask
	task automatic read_pair(output logic [15:0] v);
		pulse(READ_STB);
		@(negedge clk_i);
		v[7:0] = rd_data_i;
		pulse(READ_STB);
		@(negedge clk_i);
		v[15:8] = rd_data_i;
	endtask
	task automatic latch_read(output logic [15:0] v);
		pulse(LATCH_STB);
		read_pair(v);
	endtask
endmodule // interval_host_model

/* interval_timer.sv */
// one 16-bit down-counting interval timer channel, modes 0 to 5
// Operation
// RULE_01: rate mode: output high on programming; gate high or gate rise starts counting.
// RULE_02: rate mode: output low one clock every n counter clocks, repeating.
// RULE_03: rate mode: new count takes effect only after current pulse completes.
// RULE_04: rate mode: gate low forces output high, halts; gate rise restarts.
// RULE_05: square mode: output high on programming; start and gate as rate mode.
// RULE_06: square mode: period n; odd n gives (n+1)/2 high, (n-1)/2 low.
// RULE_07: square mode: new count applies right after the next output transition.
// RULE_08: square mode decrements by two, all other modes by one.
// RULE_09: software strobe: output high on programming; starts once count loaded, gate high.
// RULE_10: software strobe: one low pulse of one clock at terminal count.
// RULE_11: strobe low pulse comes one clock later than rate pulse.
// RULE_12: software strobe: gate low stops; gate high restarts from full count.
// RULE_13: hardware strobe: gate rise starts or retriggers; pulse as software strobe.
// RULE_14: host freezes counting before reading the count directly.
// RULE_15: latch command captures count into holding latch, counting undisturbed.
// RULE_16: two-byte access presents latched count low byte then high byte.
// RULE_17: two channels cascade into a 32-bit counter externally.
// RULE_18: terminal mode counts after full count written with gate high.
// RULE_19: one-shot: gate rise triggers, output low next clock, new count on retrigger.
// RULE_20: count zero means 10000H clocks; square count one yields 10001H (the code gives a period of 8001H).
// RULE_21: gate sampled at counter clock; loads happen on the following counter clock.
module interval_timer (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// host access
	input wire logic mode_wr_i,
	input wire logic [2:0] mode_i,
	input wire logic two_byte_i,
	input wire logic count_wr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic latch_cmd_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	// channel pins
	input wire logic cnt_clk_i,
	input wire logic gate_i,
	output logic out_o
);
	logic tick;
	logic gate_lvl;
	logic gate_seen_reg;
	logic gate_rise;
	logic [2:0] mode_reg;
	logic two_byte_reg;
	logic [15:0] cr_reg;
	logic [15:0] ce_reg;
	logic [7:0] lsb_reg;
	logic lsb_pend_reg;
	logic load_pend_reg;
	logic run_reg;
	logic strobe_reg;
	logic [15:0] latch_reg;
	logic latched_reg;
	logic rd_hi_reg;
	logic count_done;
	logic [15:0] count_full;
	logic sq_mode;

	pin_sync_edge u_clk_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(cnt_clk_i),
		.level_o(),
		.rise_o(tick)
	);

	pin_sync_edge u_gate_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(gate_i),
		.level_o(gate_lvl),
		.rise_o()
	);

	// RULE_21: gate edge between counter clocks
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			gate_seen_reg <= 1'b0;
		end else if (tick) begin
			gate_seen_reg <= gate_lvl;
		end
	end
	assign gate_rise = tick & gate_lvl & ~gate_seen_reg;

	assign count_done = count_wr_i & (~two_byte_reg | lsb_pend_reg);
	assign count_full = two_byte_reg ? {wr_data_i, lsb_reg} : {8'h00, wr_data_i};
	assign sq_mode = (mode_reg == interval_timer_pkg::MODE_SQUARE);

	// mode and access width
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			mode_reg <= interval_timer_pkg::MODE_RST;
			two_byte_reg <= 1'b0;
		end else if (mode_wr_i) begin
			mode_reg <= mode_i;
			two_byte_reg <= two_byte_i;
		end
	end

	// count register, written low byte first
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cr_reg <= interval_timer_pkg::COUNT_RST;
			lsb_reg <= interval_timer_pkg::BYTE_RST;
			lsb_pend_reg <= 1'b0;
		end else if (mode_wr_i) begin
			lsb_pend_reg <= 1'b0;
		end else if (count_wr_i) begin
			if (two_byte_reg && !lsb_pend_reg) begin
				lsb_reg <= wr_data_i;
				lsb_pend_reg <= 1'b1;
			end else begin
				cr_reg <= count_full;
				lsb_pend_reg <= 1'b0;
			end
		end
	end

	// counting engine
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ce_reg <= interval_timer_pkg::COUNT_RST;
			load_pend_reg <= 1'b0;
			run_reg <= 1'b0;
			strobe_reg <= 1'b0;
			out_o <= 1'b1;
		end else if (mode_wr_i) begin
			// RULE_01: output level set by mode
			// RULE_05: square mode starts high too
			out_o <= (mode_i != interval_timer_pkg::MODE_TERM);
			run_reg <= 1'b0;
			load_pend_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end else begin
			// RULE_18: terminal mode stops on first byte of a two-byte write
			if (count_wr_i && mode_reg == interval_timer_pkg::MODE_TERM) begin
				run_reg <= run_reg & ~(two_byte_reg & ~lsb_pend_reg);
			end
			if (count_done) begin
				case (mode_reg)
					interval_timer_pkg::MODE_TERM,
					interval_timer_pkg::MODE_SW_STROBE: begin
						// RULE_09: strobe starts after full load
						load_pend_reg <= 1'b1;
						if (mode_reg == interval_timer_pkg::MODE_TERM) begin
							out_o <= 1'b0;
						end
					end
					interval_timer_pkg::MODE_RATE,
					interval_timer_pkg::MODE_SQUARE: begin
						// RULE_03: running channel keeps its period
						if (!run_reg) begin
							load_pend_reg <= 1'b1;
						end
					end
					default: begin
						// RULE_19: one-shot waits for trigger
						load_pend_reg <= load_pend_reg;
					end
				endcase
			end
			if (mode_reg == interval_timer_pkg::MODE_ONESHOT ||
				mode_reg == interval_timer_pkg::MODE_HW_STROBE) begin
				// RULE_13: gate rise triggers and retriggers
				if (gate_rise) begin
					ce_reg <= cr_reg;
					run_reg <= 1'b1;
					strobe_reg <= 1'b0;
					out_o <= (mode_reg == interval_timer_pkg::MODE_HW_STROBE);
				end else if (tick && run_reg) begin
					ce_reg <= ce_reg - interval_timer_pkg::COUNT_ONE;
					if (strobe_reg) begin
						out_o <= 1'b1;
						strobe_reg <= 1'b0;
						run_reg <= 1'b0;
					end else if (ce_reg == interval_timer_pkg::COUNT_ONE) begin
						out_o <= (mode_reg == interval_timer_pkg::MODE_ONESHOT);
						strobe_reg <= (mode_reg == interval_timer_pkg::MODE_HW_STROBE);
						run_reg <= (mode_reg == interval_timer_pkg::MODE_HW_STROBE);
					end
				end
			end else if (!gate_lvl) begin
				// RULE_04: gate low forces high and halts
				if (mode_reg == interval_timer_pkg::MODE_RATE || sq_mode) begin
					out_o <= 1'b1;
					if (run_reg) begin
						load_pend_reg <= 1'b1;
					end
					run_reg <= 1'b0;
				end
				// RULE_12: strobe restarts from full count
				if (mode_reg == interval_timer_pkg::MODE_SW_STROBE && run_reg) begin
					load_pend_reg <= 1'b1;
					run_reg <= 1'b0;
				end
			end else if (tick && load_pend_reg && !count_done) begin
				// RULE_21: load on the counter clock after the write
				load_pend_reg <= 1'b0;
				run_reg <= 1'b1;
				strobe_reg <= 1'b0;
				// RULE_06: odd count splits high one longer
				if (sq_mode) begin
					ce_reg <= cr_reg[0] ? cr_reg + interval_timer_pkg::COUNT_ONE
						: cr_reg;
					out_o <= 1'b1;
				end else begin
					ce_reg <= cr_reg;
				end
			end else if (tick && run_reg) begin
				case (mode_reg)
					interval_timer_pkg::MODE_RATE: begin
						// RULE_02: one clock low per n clocks
						if (ce_reg == interval_timer_pkg::COUNT_ONE) begin
							out_o <= 1'b1;
							ce_reg <= cr_reg;
						end else begin
							ce_reg <= ce_reg - interval_timer_pkg::COUNT_ONE;
							out_o <= (ce_reg != interval_timer_pkg::COUNT_TWO);
						end
					end
					interval_timer_pkg::MODE_SQUARE: begin
						// RULE_08: square mode steps by two
						if (ce_reg == interval_timer_pkg::COUNT_TWO) begin
							// RULE_07: new count at each transition
							out_o <= ~out_o;
							if (cr_reg[0]) begin
								// RULE_20: count one runs 8001H, one clock high and 8000H low
								ce_reg <= out_o ? cr_reg - interval_timer_pkg::COUNT_ONE
									: cr_reg + interval_timer_pkg::COUNT_ONE;
							end else begin
								ce_reg <= cr_reg;
							end
						end else begin
							ce_reg <= ce_reg - interval_timer_pkg::COUNT_TWO;
						end
					end
					interval_timer_pkg::MODE_SW_STROBE: begin
						// RULE_10: single strobe then stop
						// RULE_11: low one clock after rate pulse
						ce_reg <= ce_reg - interval_timer_pkg::COUNT_ONE;
						if (strobe_reg) begin
							out_o <= 1'b1;
							strobe_reg <= 1'b0;
							run_reg <= 1'b0;
						end else if (ce_reg == interval_timer_pkg::COUNT_ONE) begin
							out_o <= 1'b0;
							strobe_reg <= 1'b1;
						end
					end
					default: begin
						// zero count wraps, giving 10000H clocks
						ce_reg <= ce_reg - interval_timer_pkg::COUNT_ONE;
						if (ce_reg == interval_timer_pkg::COUNT_ONE) begin
							out_o <= 1'b1;
							run_reg <= 1'b0;
						end
					end
				endcase
			end
		end
	end

	// RULE_15: latch holds until fully read
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			latch_reg <= interval_timer_pkg::COUNT_RST;
			latched_reg <= 1'b0;
		end else if (mode_wr_i) begin
			latched_reg <= 1'b0;
		end else if (latch_cmd_i && !latched_reg) begin
			latch_reg <= ce_reg;
			latched_reg <= 1'b1;
		end else if (rd_i && (rd_hi_reg || !two_byte_reg)) begin
			latched_reg <= 1'b0;
		end
	end

	// RULE_16: low byte then high byte
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_hi_reg <= 1'b0;
			rd_data_o <= interval_timer_pkg::BYTE_RST;
		end else if (mode_wr_i) begin
			rd_hi_reg <= 1'b0;
		end else if (rd_i) begin
			// RULE_14: direct read unsynchronised, host freezes first
			if (rd_hi_reg) begin
				rd_data_o <= latched_reg ? latch_reg[15:8] : ce_reg[15:8];
			end else begin
				rd_data_o <= latched_reg ? latch_reg[7:0] : ce_reg[7:0];
			end
			rd_hi_reg <= two_byte_reg & ~rd_hi_reg;
		end
	end
endmodule // interval_timer

/* interval_timer_chk.sv */
// port checker for the interval timer channel
module interval_timer_chk (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// host access
	input wire logic mode_wr_i,
	input wire logic [2:0] mode_i,
	input wire logic count_wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_data_o,
	// channel pins
	input wire logic gate_i,
	input wire logic out_o
);
	logic [2:0] mode_reg;
	logic [1:0] pulse_reg;
	logic rate, sq, strobe;
	assign rate = mode_reg == interval_timer_pkg::MODE_RATE;
	assign sq = mode_reg == interval_timer_pkg::MODE_SQUARE;
	assign strobe = mode_reg inside {interval_timer_pkg::MODE_SW_STROBE,
		interval_timer_pkg::MODE_HW_STROBE};
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) mode_reg <= interval_timer_pkg::MODE_RST;
		else if (mode_wr_i) mode_reg <= mode_i;
	end
	// low gate or a reload legitimately re-arms the strobe
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) pulse_reg <= 2'h0;
		else if (mode_wr_i || count_wr_i || !gate_i) pulse_reg <= 2'h0;
		else if ($fell(out_o) && pulse_reg != 2'h3) pulse_reg <= pulse_reg + 2'h1;
	end
	prog_high_a: assert property (mode_wr_i && mode_i inside {[3'h2:3'h5]} |=> out_o)
		else $error("output not high after programming");
	gate_force_a: assert property (((rate || sq) && !gate_i) [*5] |-> out_o)
		else $error("output not forced high by low gate");
	rate_pulse_a: assert property (rate && $fell(out_o) |-> ##[1:12] out_o)
		else $error("rate pulse too long");
	strobe_pulse_a: assert property (strobe && $fell(out_o) |-> ##[1:12] out_o)
		else $error("strobe pulse too long");
	single_pulse_a: assert property (strobe |-> pulse_reg < 2'h2)
		else $error("strobe repeated");
	rd_hold_a: assert property (!rd_i |=> $stable(rd_data_o))
		else $error("read byte changed without read");
	square_high_a: assert property (sq && $rose(out_o) |-> out_o [*4])
		else $error("square high phase too short");
	reset_idle_a: assert property ($rose(arst_n_i) |-> out_o && rd_data_o == 8'h00)
		else $error("reset state wrong");
endmodule // interval_timer_chk

bind interval_timer interval_timer_chk chk_u (.clk_i, .arst_n_i, .mode_wr_i, .mode_i,
	.count_wr_i, .rd_i, .rd_data_o, .gate_i, .out_o);

/* interval_timer_pkg.sv */
// shared constants for the interval timer channel
package interval_timer_pkg;
	localparam int CNT_W = 16;
	localparam logic [2:0] MODE_TERM = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SW_STROBE = 3'h4;
	localparam logic [2:0] MODE_HW_STROBE = 3'h5;
	localparam logic [2:0] MODE_RST = MODE_RATE;
	localparam logic [15:0] COUNT_RST = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_TWO = 16'h0002;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam int SYNC_STAGES = 2;
endpackage

/* interval_timer_tb.sv */
// testbench for the interval timer channel
module interval_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic cnt_clk_i = 1'b0;
	logic gate_i = 1'b1;
	logic mode_wr_i, two_byte_i, count_wr_i, latch_cmd_i, rd_i, out_o;
	logic [2:0] mode_i;
	logic [7:0] wr_data_i, rd_data_o;
	int error_cnt = 0;
	int tests_run = 0;
	int cycles = 0;
	int rate_first;
	int lows, first;
	logic [15:0] v;
	initial begin
		forever #10 clk_i = ~clk_i;
	end
	interval_timer dut_u (.clk_i, .arst_n_i, .mode_wr_i, .mode_i, .two_byte_i, .count_wr_i,
		.wr_data_i, .latch_cmd_i, .rd_i, .rd_data_o, .cnt_clk_i, .gate_i, .out_o);
	interval_host_model host_u (.clk_i, .mode_wr_o(mode_wr_i), .mode_o(mode_i),
		.two_byte_o(two_byte_i), .count_wr_o(count_wr_i), .wr_data_o(wr_data_i),
		.latch_cmd_o(latch_cmd_i), .rd_o(rd_i), .rd_data_i(rd_data_o));
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// output sampled just before each counter clock rise, 8 clocks apart
	task automatic run_ticks(input int n);
		lows = 0;
		first = 0;
		for (int i = 1; i <= n; i++) begin
			@(negedge clk_i);
			if (out_o === 1'b0) begin
				lows++;
				if (first == 0) first = i;
			end
			cnt_clk_i = 1'b1;
			repeat (4) @(negedge clk_i);
			cnt_clk_i = 1'b0;
			repeat (3) @(negedge clk_i);
		end
	endtask
	task automatic rate_test;
		host_u.set_mode(interval_timer_pkg::MODE_RATE, 1'b0);
		host_u.write_count(16'h0003, 1'b0);
		run_ticks(12);
		check("rate lows", 16'h0003, 16'(lows));
		rate_first = first;
		check("rate slot", 16'h0004, 16'(first));
		gate_i = 1'b0;
		// gate passes two sync flops before it forces the output
		repeat (4) @(negedge clk_i);
		run_ticks(6);
		check("gated lows", 16'h0000, 16'(lows));
		gate_i = 1'b1;
		run_ticks(12);
		check("regated lows", 16'h0003, 16'(lows));
	endtask
	task automatic square_test;
		host_u.set_mode(interval_timer_pkg::MODE_SQUARE, 1'b0);
		host_u.write_count(16'h0005, 1'b0);
		run_ticks(2);
		run_ticks(10);
		check("square lows", 16'h0004, 16'(lows));
	endtask
	task automatic strobe_test;
		host_u.set_mode(interval_timer_pkg::MODE_SW_STROBE, 1'b0);
		host_u.write_count(16'h0003, 1'b0);
		run_ticks(12);
		check("strobe lows", 16'h0001, 16'(lows));
		check("strobe slot", 16'(rate_first + 1), 16'(first));
		gate_i = 1'b0;
		host_u.set_mode(interval_timer_pkg::MODE_HW_STROBE, 1'b0);
		host_u.write_count(16'h0002, 1'b0);
		run_ticks(4);
		check("idle lows", 16'h0000, 16'(lows));
		gate_i = 1'b1;
		run_ticks(8);
		check("trigger lows", 16'h0001, 16'(lows));
	endtask
	// one-shot: a count write alone never starts it
	task automatic oneshot_test;
		gate_i = 1'b0;
		host_u.set_mode(interval_timer_pkg::MODE_ONESHOT, 1'b0);
		host_u.write_count(16'h0002, 1'b0);
		run_ticks(2);
		check("untriggered lows", 16'h0000, 16'(lows));
		gate_i = 1'b1;
		run_ticks(6);
		check("oneshot lows", 16'h0002, 16'(lows));
	endtask
	// counter clock held still around each latch
	task automatic latch_test;
		// terminal channel as upper half, bench ticks stand in for the lower
		host_u.set_mode(interval_timer_pkg::MODE_TERM, 1'b1);
		host_u.write_count(16'h1234, 1'b1);
		run_ticks(1);
		host_u.latch_read(v);
		check("loaded count", 16'h1234, v);
		run_ticks(2);
		host_u.latch_read(v);
		check("latched count", 16'h1232, v);
		// gate held low freezes the count before a direct read
		gate_i = 1'b0;
		run_ticks(2);
		host_u.read_pair(v);
		check("frozen count", 16'h1232, v);
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(negedge clk_i);
		arst_n_i = 1'b1;
		rate_test();
		square_test();
		strobe_test();
		oneshot_test();
		latch_test();
		report_and_stop();
	end
endmodule // interval_timer_tb

/* pin_sync_edge.sv */
// two-flop synchroniser with rising edge detect for one pin
module pin_sync_edge (
	// clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// pin side
	input wire logic pin_i,
	// synchronised side
	output logic level_o,
	output logic rise_o
);
	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o = sync_reg & ~prev_reg;
endmodule // pin_sync_edge
